// >>> shared/xtc_consts.vh
// How it works
// - control flag low: byte goes out as a data code group unchanged.
// - all-idle column idle bytes become K28.0, K28.3 or K28.5.
// - idle sharing a column with terminate always becomes K28.5.
// - sequence, start, terminate, error map to K28.4, K27.7, K29.7, K30.7.
// - undefined control bytes become K30.7, the invalid marker.
// - reserved control bytes map to their reserved code groups.
// - idle choice between K28.0 and K28.5 follows PRBS x^7+x^6+1.
// - K28.3 inserted after 16 to 31 other idle code groups.
// - serializer loads parallel word, shifts it out least significant bit first.
// - force-idle input puts transmitter in electrical idle, PCIe mode only.
// - lock-to-data wins; lock-to-reference alone; neither selects automatic.
// - unconnected lock inputs default to automatic lock mode.
// - automatic mode switches on phase and frequency-offset detector results.
// - two lock indications: locked to reference, locked to data.
`ifndef XTC_CONSTS_VH
`define XTC_CONSTS_VH

`define XTC_CH_IDLE      8'h07
`define XTC_CH_SEQ       8'h9C
`define XTC_CH_START     8'hFB
`define XTC_CH_TERM      8'hFD
`define XTC_CH_ERR       8'hFE
`define XTC_CH_RES0      8'h1C
`define XTC_CH_RES1      8'h3C
`define XTC_CH_RES2      8'h7C
`define XTC_CH_RES3      8'hBC
`define XTC_CH_RES4      8'hDC
`define XTC_CH_RES5      8'hF7

`define XTC_K28_0        8'h1C
`define XTC_K28_3        8'h7C
`define XTC_K28_4        8'h9C
`define XTC_K28_5        8'hBC
`define XTC_K27_7        8'hFB
`define XTC_K29_7        8'hFD
`define XTC_K30_7        8'hFE

`define XTC_ALIGN_MIN    5'h10
`define XTC_PRBS_SEED    7'h7F
`define XTC_PRBS_TAP_HI  6
`define XTC_PRBS_TAP_LO  5

`define XTC_WORD_W       10
`define XTC_CNT_W        4
`define XTC_SHIFT_RST    10'h000

`define XTC_LOCK_AUTO    2'h0
`define XTC_LOCK_REF     2'h1
`define XTC_LOCK_DATA    2'h2

`define XTC_LOCK_HOLD_NS 100
`define XTC_CLK_PERIOD_NS 5
`define XTC_LOCK_HOLD_CYC (`XTC_LOCK_HOLD_NS / `XTC_CLK_PERIOD_NS)
// last count of the reference-lock hold, one below the cycle count
`define XTC_LOCK_HOLD_LAST 5'h13

`endif

// >>> logic/xtc_skid_buf.v
`timescale 1ns/10ps
// two-entry buffer: holds a word while the downstream stalls
module xtc_skid_buf #(
    parameter W = 18
) (
    mclk,
    sys_rst,
    in_valid,
    in_ready,
    in_data,
    out_valid,
    out_ready,
    out_data
);
    input  wire         mclk;
    input  wire         sys_rst;
    input  wire         in_valid;
    output wire         in_ready;
    input  wire [W-1:0] in_data;
    output wire         out_valid;
    input  wire         out_ready;
    output wire [W-1:0] out_data;

    reg [W-1:0] mem_q [0:1];
    reg         wr_q;
    reg         rd_q;
    reg [1:0]   cnt_q;

    wire push = in_valid && (cnt_q != 2'h2);
    wire pop  = (cnt_q != 2'h0) && out_ready;

    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rd_q];

    always @(posedge mclk) begin
        if (sys_rst) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 2'h1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 2'h1;
            end
        end
    end

    always @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule // xtc_skid_buf

// >>> logic/xtc_serializer.v
`timescale 1ns/10ps
`include "xtc_consts.vh"
// loads one parallel word, shifts it out lsb first, one bit per clock
module xtc_serializer (
    mclk,
    sys_rst,
    word_wide,
    in_valid,
    in_ready,
    in_word,
    ser_bit,
    ser_active
);
    input  wire                   mclk;
    input  wire                   sys_rst;
    input  wire                   word_wide;
    input  wire                   in_valid;
    output wire                   in_ready;
    input  wire [`XTC_WORD_W-1:0] in_word;
    output reg                    ser_bit;
    output reg                    ser_active;

    reg [`XTC_WORD_W-1:0] shift_q;
    reg [`XTC_CNT_W-1:0]  left_q;

    assign in_ready = (left_q == 4'h0) || (left_q == 4'h1);

    always @(posedge mclk) begin
        if (sys_rst) begin
            shift_q    <= `XTC_SHIFT_RST;
            left_q     <= 4'h0;
            ser_bit    <= 1'b0;
            ser_active <= 1'b0;
        end else if (in_valid && in_ready) begin
            ser_bit    <= in_word[0];
            shift_q    <= {1'b0, in_word[`XTC_WORD_W-1:1]};
            left_q     <= word_wide ? 4'hA : 4'h8;
            ser_active <= 1'b1;
        end else if (left_q != 4'h0) begin
            ser_bit    <= shift_q[0];
            shift_q    <= {1'b0, shift_q[`XTC_WORD_W-1:1]};
            left_q     <= left_q - 4'h1;
            ser_active <= (left_q != 4'h1);
        end else begin
            ser_active <= 1'b0;
        end
    end
endmodule // xtc_serializer

// >>> logic/xtc_tx_lane.v
`timescale 1ns/10ps
`include "xtc_consts.vh"
module xtc_tx_lane (
    mclk,
    sys_rst,
    txd,
    txc,
    col_has_term,
    col_all_idle,
    tx_valid,
    tx_ready,
    word_wide,
    pcie_mode,
    force_elec_idle,
    lock_to_ref,
    lock_to_data,
    data_lock_detector,
    reference_lock_detector,
    cg_data,
    cg_ctrl,
    ser_bit,
    tx_elec_idle,
    clock_recovery_unit_mode,
    locked_to_ref,
    locked_to_data
);
    input  wire       mclk;
    input  wire       sys_rst;
    input  wire [7:0] txd;
    input  wire       txc;
    input  wire       col_has_term;
    input  wire       col_all_idle;
    input  wire       tx_valid;
    output reg        tx_ready;
    input  wire       word_wide;
    input  wire       pcie_mode;
    input  wire       force_elec_idle;
    input  wire       lock_to_ref;
    input  wire       lock_to_data;
    input  wire       data_lock_detector;
    input  wire       reference_lock_detector;
    output reg  [7:0] cg_data;
    output reg        cg_ctrl;
    output reg        ser_bit;
    output reg        tx_elec_idle;
    output reg  [1:0] clock_recovery_unit_mode;
    output reg        locked_to_ref;
    output reg        locked_to_data;

    // two-flop synchronisers for pin-level inputs
    reg [4:0] pin_s1_q;
    reg [4:0] pin_s2_q;
    always @(posedge mclk) begin
        if (sys_rst) begin
            pin_s1_q <= 5'h00;
            pin_s2_q <= 5'h00;
        end else begin
            pin_s1_q <= {force_elec_idle, lock_to_ref, lock_to_data,
                         data_lock_detector, reference_lock_detector};
            pin_s2_q <= pin_s1_q;
        end
    end
    wire fei_s   = pin_s2_q[4];
    wire lref_s  = pin_s2_q[3];
    wire ldata_s = pin_s2_q[2];
    wire pd_s    = pin_s2_q[1];
    wire pfd_s   = pin_s2_q[0];

    // input buffer
    wire       ib_valid;
    wire       ib_ready;
    wire [10:0] ib_data;
    wire       ib_in_ready;
    xtc_skid_buf #(.W(11)) u_in_buf (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .in_valid  (tx_valid),
        .in_ready  (ib_in_ready),
        .in_data   ({col_all_idle, col_has_term, txc, txd}),
        .out_valid (ib_valid),
        .out_ready (ib_ready),
        .out_data  (ib_data)
    );
    always @(posedge mclk) begin
        if (sys_rst) begin
            tx_ready <= 1'b0;
        end else begin
            // look-ahead: high exactly when the next offer will be taken
            tx_ready <= (ib_valid && ib_ready) || (ib_in_ready && !(ib_valid && tx_valid));
        end
    end

    wire [7:0] b_d    = ib_data[7:0];
    wire       b_c    = ib_data[8];
    wire       b_term = ib_data[9];

    // idle randomiser and alignment spacing
    reg [6:0] prbs_q;
    reg [4:0] gap_q;
    wire      prbs_fb = prbs_q[`XTC_PRBS_TAP_HI] ^ prbs_q[`XTC_PRBS_TAP_LO];
    wire      is_idle = b_c && (b_d == `XTC_CH_IDLE);

    // encoder
    reg [7:0] enc_d;
    reg       enc_idle_a;
    always @* begin
        enc_d      = `XTC_K30_7;
        enc_idle_a = 1'b0;
        if (!b_c) begin
            enc_d = b_d;
        end else if (b_d == `XTC_CH_IDLE) begin
            if (b_term) begin
                enc_d = `XTC_K28_5;
            end else if (gap_q == 5'h00) begin
                enc_d      = `XTC_K28_3;
                enc_idle_a = 1'b1;
            end else if (prbs_q[0]) begin
                enc_d = `XTC_K28_5;
            end else begin
                enc_d = `XTC_K28_0;
            end
        end else if (b_d == `XTC_CH_SEQ) begin
            enc_d = `XTC_K28_4;
        end else if (b_d == `XTC_CH_START) begin
            enc_d = `XTC_K27_7;
        end else if (b_d == `XTC_CH_TERM) begin
            enc_d = `XTC_K29_7;
        end else if (b_d == `XTC_CH_ERR) begin
            enc_d = `XTC_K30_7;
        end else if ((b_d == `XTC_CH_RES0) || (b_d == `XTC_CH_RES1) || (b_d == `XTC_CH_RES2) ||
                     (b_d == `XTC_CH_RES3) || (b_d == `XTC_CH_RES4) || (b_d == `XTC_CH_RES5)) begin
            enc_d = b_d;
        end
    end

    // output buffer to serializer
    wire       ob_in_ready;
    wire       ob_valid;
    wire       ob_ready;
    wire [8:0] ob_data;
    assign ib_ready = ob_in_ready;
    wire fire = ib_valid && ob_in_ready;

    always @(posedge mclk) begin
        if (sys_rst) begin
            prbs_q <= `XTC_PRBS_SEED;
            gap_q  <= `XTC_ALIGN_MIN;
        end else if (fire && is_idle && !b_term) begin
            prbs_q <= {prbs_q[5:0], prbs_fb};
            if (enc_idle_a) begin
                gap_q <= `XTC_ALIGN_MIN | {1'b0, prbs_q[3:0]};
            end else begin
                gap_q <= gap_q - 5'h01;
            end
        end
    end

    xtc_skid_buf #(.W(9)) u_out_buf (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .in_valid  (ib_valid),
        .in_ready  (ob_in_ready),
        .in_data   ({b_c, enc_d}),
        .out_valid (ob_valid),
        .out_ready (ob_ready),
        .out_data  (ob_data)
    );

    // code group word to serializer: control flag rides in bit 8
    wire ser_out;
    wire ser_act;
    xtc_serializer u_ser (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .word_wide  (word_wide),
        .in_valid   (ob_valid),
        .in_ready   (ob_ready),
        .in_word    ({1'b0, ob_data}),
        .ser_bit    (ser_out),
        .ser_active (ser_act)
    );

    always @(posedge mclk) begin
        if (sys_rst) begin
            cg_data <= 8'h00;
            cg_ctrl <= 1'b0;
        end else if (ob_valid && ob_ready) begin
            cg_data <= ob_data[7:0];
            cg_ctrl <= ob_data[8];
        end
    end

    // electrical idle, only honoured in pcie mode
    wire elec_idle_d = pcie_mode && fei_s;
    always @(posedge mclk) begin
        if (sys_rst) begin
            tx_elec_idle <= 1'b0;
            ser_bit      <= 1'b0;
        end else begin
            tx_elec_idle <= elec_idle_d;
            ser_bit      <= (elec_idle_d || !ser_act) ? 1'b0 : ser_out;
        end
    end

    // lock mode select and automatic switching
    reg [1:0] mode_d;
    always @* begin
        if (ldata_s) begin
            mode_d = `XTC_LOCK_DATA;
        end else if (lref_s) begin
            mode_d = `XTC_LOCK_REF;
        end else begin
            mode_d = `XTC_LOCK_AUTO;
        end
    end

    reg       auto_data_q;
    reg [4:0] hold_q;
    always @(posedge mclk) begin
        if (sys_rst) begin
            auto_data_q <= 1'b0;
            hold_q      <= 5'h00;
        end else if (!auto_data_q) begin
            if (pfd_s) begin
                if (hold_q == `XTC_LOCK_HOLD_LAST) begin
                    auto_data_q <= 1'b1;
                    hold_q      <= 5'h00;
                end else begin
                    hold_q <= hold_q + 5'h01;
                end
            end else begin
                hold_q <= 5'h00;
            end
        end else if (!pd_s && !pfd_s) begin
            auto_data_q <= 1'b0;
        end
    end

    wire on_data = (mode_d == `XTC_LOCK_DATA) || ((mode_d == `XTC_LOCK_AUTO) && auto_data_q);
    always @(posedge mclk) begin
        if (sys_rst) begin
            clock_recovery_unit_mode <= `XTC_LOCK_AUTO;
            locked_to_ref            <= 1'b0;
            locked_to_data           <= 1'b0;
        end else begin
            clock_recovery_unit_mode <= mode_d;
            locked_to_ref            <= !on_data && pfd_s;
            locked_to_data           <= on_data && pd_s;
        end
    end
endmodule // xtc_tx_lane

// >>> verification/xtc_tx_lane_monitor.sv
`timescale 1ns/10ps
`include "xtc_consts.vh"
module xtc_tx_lane_monitor (
    input wire       mclk,
    input wire       sys_rst,
    input wire       pcie_mode,
    input wire       force_elec_idle,
    input wire       lock_to_ref,
    input wire       lock_to_data,
    input wire       tx_ready,
    input wire [7:0] cg_data,
    input wire       cg_ctrl,
    input wire       ser_bit,
    input wire       tx_elec_idle,
    input wire [1:0] clock_recovery_unit_mode,
    input wire       locked_to_data
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    property p_lock_data; lock_to_data [*6] |-> clock_recovery_unit_mode == `XTC_LOCK_DATA; endproperty
    a_lock_data: assert property (p_lock_data) else $error("lock to data not forced");
    property p_lock_ref; (lock_to_ref && !lock_to_data) [*6] |-> clock_recovery_unit_mode == `XTC_LOCK_REF; endproperty
    a_lock_ref: assert property (p_lock_ref) else $error("lock to reference not forced");
    property p_lock_auto; (!lock_to_ref && !lock_to_data) [*6] |-> clock_recovery_unit_mode == `XTC_LOCK_AUTO; endproperty
    a_lock_auto: assert property (p_lock_auto) else $error("automatic lock not selected");
    property p_eidle_on; (pcie_mode && force_elec_idle) [*6] |-> tx_elec_idle; endproperty
    a_eidle_on: assert property (p_eidle_on) else $error("electrical idle not entered");
    property p_eidle_off; !pcie_mode [*3] |-> !tx_elec_idle; endproperty
    a_eidle_off: assert property (p_eidle_off) else $error("electrical idle outside pcie mode");
    property p_eidle_rel; !force_elec_idle [*6] |-> !tx_elec_idle; endproperty
    a_eidle_rel: assert property (p_eidle_rel) else $error("electrical idle not left");
    property p_eidle_quiet; tx_elec_idle [*3] |-> !ser_bit; endproperty
    a_eidle_quiet: assert property (p_eidle_quiet) else $error("serial line active in idle");
    property p_k_legal; cg_ctrl |-> cg_data inside {`XTC_K28_0, `XTC_K28_3, `XTC_K28_4, `XTC_K28_5, `XTC_K27_7,
        `XTC_K29_7, `XTC_K30_7, `XTC_CH_RES1, `XTC_CH_RES4, `XTC_CH_RES5}; endproperty
    a_k_legal: assert property (p_k_legal) else $error("illegal control code group");
    property p_rst_clear; $fell(sys_rst) |-> !tx_ready && !cg_ctrl && cg_data == 8'h00; endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared by reset");
    c_full: cover property (!tx_ready);
    c_align: cover property (cg_ctrl && cg_data == `XTC_K28_3);
    c_eidle: cover property (tx_elec_idle);
    c_dlock: cover property (locked_to_data);
endmodule // xtc_tx_lane_monitor
bind xtc_tx_lane xtc_tx_lane_monitor mon_u (.mclk, .sys_rst, .pcie_mode, .force_elec_idle, .lock_to_ref,
    .lock_to_data, .tx_ready, .cg_data, .cg_ctrl, .ser_bit, .tx_elec_idle, .clock_recovery_unit_mode, .locked_to_data);

// >>> verification/xtc_link_partner.sv
`timescale 1ns/10ps
// remote deserializer: frames from the first change of cg_data after reset
module xtc_link_partner (
    input  wire       mclk,
    input  wire       sys_rst,
    input  wire       word_wide,
    input  wire       ser_bit,
    input  wire [7:0] cg_data,
    output reg  [9:0] rx_word,
    output reg        rx_stb
);
    reg [7:0] prev_q;
    reg       on_q;
    reg [3:0] cnt_q;
    reg [9:0] sh_q;
    reg [9:0] w;
    initial rx_stb = 1'b0;
    initial rx_word = 10'h000;
    always @(posedge mclk) begin
        rx_stb <= 1'b0;
        prev_q <= cg_data;
        w = sh_q;
        w[cnt_q] = ser_bit;
        if (sys_rst) begin
            on_q <= 1'b0;
            cnt_q <= 4'h0;
            sh_q <= 10'h000;
        end else if (!on_q) begin
            on_q <= cg_data != prev_q;
        end else if (cnt_q == (word_wide ? 4'h9 : 4'h7)) begin
            rx_word <= w;
            rx_stb <= 1'b1;
            cnt_q <= 4'h0;
            sh_q <= 10'h000;
        end else begin
            sh_q <= w;
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule // xtc_link_partner

// >>> verification/xtc_tx_lane_tb.sv
`timescale 1ns/10ps
`include "xtc_consts.vh"
module xtc_tx_lane_tb;
    reg        mclk = 1'b0;
    reg        sys_rst = 1'b1;
    reg  [7:0] txd = 8'h00;
    reg        txc = 1'b0;
    reg        col_has_term = 1'b0;
    reg        col_all_idle = 1'b0;
    reg        tx_valid = 1'b0;
    reg        word_wide = 1'b1;
    reg        pcie_mode = 1'b0;
    reg        force_elec_idle = 1'b0;
    reg        lock_to_ref = 1'b0;
    reg        lock_to_data = 1'b0;
    reg        data_lock_detector = 1'b0;
    reg        reference_lock_detector = 1'b0;
    wire       tx_ready, cg_ctrl, ser_bit, tx_elec_idle, locked_to_ref, locked_to_data, rx_stb;
    wire [7:0] cg_data;
    wire [1:0] clock_recovery_unit_mode;
    wire [9:0] rx_word;
    int        n_fail = 0;
    int        total_checks = 0;
    bit        saw_full = 1'b0;
    reg  [9:0] rxq[$];
    xtc_tx_lane dut_u (.mclk, .sys_rst, .txd, .txc, .col_has_term, .col_all_idle, .tx_valid, .tx_ready,
        .word_wide, .pcie_mode, .force_elec_idle, .lock_to_ref, .lock_to_data, .data_lock_detector,
        .reference_lock_detector, .cg_data, .cg_ctrl, .ser_bit, .tx_elec_idle, .clock_recovery_unit_mode,
        .locked_to_ref, .locked_to_data);
    xtc_link_partner peer_u (.mclk, .sys_rst, .word_wide, .ser_bit, .cg_data, .rx_word, .rx_stb);
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (rx_stb) rxq.push_back(rx_word);
    task test_done;
        if (n_fail == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input bit ok, input string m);
        total_checks++;
        if (!ok) begin
            n_fail++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask
    task wait_n(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task rst;
        sys_rst <= 1'b1;
        wait_n(8);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rxq.delete();
    endtask
    task send(input bit t, input bit c, input [7:0] d);
        int i;
        txc <= c;
        txd <= d;
        col_has_term <= t;
        col_all_idle <= c && d == `XTC_CH_IDLE && !t;
        tx_valid <= 1'b1;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
            saw_full = saw_full | (tx_ready !== 1'b1);
        end while (tx_ready !== 1'b1 && i < 99);
        tx_valid <= 1'b0;
        @(posedge mclk);
    endtask
    task grab(input int n);
        int i;
        for (i = 0; i < 2000 && rxq.size() < n; i++) @(posedge mclk);
        chk(rxq.size() >= n, "words lost");
    endtask
    function [9:0] enc(input [9:0] e);
        if (!e[8]) return {2'b00, e[7:0]};
        case (e[7:0])
            `XTC_CH_IDLE: return {2'b01, `XTC_K28_5};
            `XTC_CH_SEQ, `XTC_CH_START, `XTC_CH_TERM, `XTC_CH_ERR, `XTC_CH_RES0, `XTC_CH_RES1,
            `XTC_CH_RES2, `XTC_CH_RES3, `XTC_CH_RES4, `XTC_CH_RES5: return {2'b01, e[7:0]};
            default: return {2'b01, `XTC_K30_7};
        endcase
    endfunction
    // {term, ctrl, byte}; words pushed faster than the serializer drains
    task t_codes;
        reg [9:0] cw[15];
        int k;
        cw = '{10'h0C1, 10'h000, 10'h0FF, 10'h19C, 10'h1FB, 10'h1FD, 10'h1FE, 10'h11C,
               10'h13C, 10'h17C, 10'h1BC, 10'h1DC, 10'h1F7, 10'h155, 10'h307};
        rst;
        for (k = 0; k < 15; k++) send(cw[k][9], cw[k][8], cw[k][7:0]);
        grab(15);
        for (k = 0; k < 15; k++) chk(rxq[k] === enc(cw[k]), "code group");
        chk(saw_full, "buffer never refused");
        chk(tx_ready === 1'b1 && ser_bit === 1'b0, "drained link not quiet");
    endtask
    task t_idle;
        int k, gap, n0, n5;
        rst;
        send(1'b0, 1'b0, 8'hC1);
        for (k = 0; k < 70; k++) send(1'b0, 1'b1, `XTC_CH_IDLE);
        grab(71);
        gap = 0;
        n0 = 0;
        n5 = 0;
        for (k = 1; k < 71; k++) begin
            if (rxq[k] === {2'b01, `XTC_K28_3}) begin
                chk(gap >= 16 && gap <= 31, "align spacing");
                gap = 0;
            end else begin
                chk(rxq[k] === {2'b01, `XTC_K28_0} || rxq[k] === {2'b01, `XTC_K28_5}, "idle code");
                gap++;
                n5 += rxq[k][7];
                n0 += !rxq[k][7];
            end
        end
        chk(gap <= 31, "align missing");
        chk(n0 > 0 && n5 > 0, "idle not randomized");
    endtask
    task t_narrow;
        word_wide <= 1'b0;
        rst;
        send(1'b0, 1'b0, 8'hC1);
        send(1'b0, 1'b0, 8'h36);
        send(1'b0, 1'b1, `XTC_CH_START);
        grab(3);
        chk(rxq[0][7:0] === 8'hC1 && rxq[1][7:0] === 8'h36 && rxq[2][7:0] === `XTC_K27_7, "narrow word");
        word_wide <= 1'b1;
    endtask
    task t_eidle;
        int k;
        bit quiet;
        force_elec_idle <= 1'b1;
        wait_n(8);
        chk(tx_elec_idle === 1'b0, "idle outside pcie mode");
        pcie_mode <= 1'b1;
        wait_n(8);
        chk(tx_elec_idle === 1'b1 && ser_bit === 1'b0, "electrical idle");
        // an all-ones word must not reach the line while idle
        send(1'b0, 1'b0, 8'hFF);
        quiet = 1'b1;
        for (k = 0; k < 14; k++) begin
            @(posedge mclk);
            quiet = quiet && ser_bit === 1'b0;
        end
        chk(quiet && cg_data === 8'hFF && cg_ctrl === 1'b0, "word leaked in electrical idle");
        force_elec_idle <= 1'b0;
        wait_n(8);
        chk(tx_elec_idle === 1'b0, "idle release");
        pcie_mode <= 1'b0;
    endtask
    // {ref, data, expected mode}
    task t_lock;
        reg [3:0] lt[4];
        int k;
        lt = '{4'h9, 4'h6, 4'hE, 4'h0};
        for (k = 0; k < 4; k++) begin
            lock_to_ref <= lt[k][3];
            lock_to_data <= lt[k][2];
            wait_n(8);
            chk(clock_recovery_unit_mode === lt[k][1:0], "lock mode");
        end
        reference_lock_detector <= 1'b1;
        data_lock_detector <= 1'b1;
        wait_n(10);
        chk(locked_to_ref === 1'b1 && locked_to_data === 1'b0, "reference lock");
        wait_n(`XTC_LOCK_HOLD_CYC + 10);
        chk(locked_to_data === 1'b1, "data lock");
        reference_lock_detector <= 1'b0;
        data_lock_detector <= 1'b0;
        wait_n(10);
        chk(locked_to_data === 1'b0, "lock loss");
    endtask
    initial begin
        t_codes;
        t_idle;
        t_narrow;
        t_eidle;
        t_lock;
        test_done;
    end
    initial begin
        wait_n(20000);
        n_fail++;
        test_done;
    end
endmodule // xtc_tx_lane_tb
